/* rtl/dasc_ctrl.sv */
// Command interpreter for detector selection, offset zeroing and analog scans
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////
module dasc_ctrl #(
    parameter int STEP_SETTLE_NS = 1000
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // Register port
    input wire dasc_pkg::dasc_bus_t bus,
    output logic [31:0] rdata,
    // Pins
    input wire logic overpressure_pin,
    input wire logic option_pin,
    // Electrometer
    output dasc_pkg::dasc_meas_t meas,
    input wire logic meas_done,
    input wire logic signed [31:0] meas_value,
    output logic [15:0] step_idx,
    // Host byte stream
    output dasc_pkg::dasc_tx_t tx,
    input wire logic tx_ready,
    // Status
    output logic multiplier_indicator,
    output logic scan_busy
);
    import dasc_pkg::*;

    // Least settle time at fastest rate, rounded up
    localparam int SETTLE_CYC = (STEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [2:0] op_sync;
        logic [2:0] opt_sync;
        logic op_filt;
        logic opt_filt;
        logic [31:0] rdata;
        logic [2:0] nf;
        logic [7:0] first_mass;
        logic [7:0] final_mass;
        logic [7:0] steps_per_amu;
        logic [7:0] status;
        logic [11:0] bias;
        logic mult;
        logic total_pressure_allowed;
        dasc_state_t state;
        logic busy;
        logic scan_mult;
        logic [2:0] scan_nf;
        logic cont;
        logic [15:0] scans_left;
        logic [15:0] points;
        logic [15:0] idx;
        logic [23:0] settle_cnt;
        logic [31:0] resp;
        logic [2:0] resp_cnt;
        dasc_meas_t meas;
        dasc_tx_t tx;
        logic [15:0][31:0] ofs;
    } dasc_st_t;

    dasc_st_t st_r;
    dasc_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] ofs_idx(input logic mult, input logic [2:0] nf);
        ofs_idx = {mult, nf};
    endfunction : ofs_idx

    function automatic logic [15:0] scan_points(input logic [7:0] first,
                                                input logic [7:0] last,
                                                input logic [7:0] steps);
        logic [15:0] span;
        span = 16'((last - first) * steps);
        scan_points = span + 16'h0001;
    endfunction : scan_points

    function automatic logic [23:0] settle_len(input logic [2:0] nf);
        settle_len = 24'(SETTLE_CYC) << (NF_FAST - nf);
    endfunction : settle_len

    logic [31:0] corr;
    logic [31:0] sent;
    dasc_cmd_t cmd;
    logic [CMD_ARG_W-1:0] arg;

    always_comb begin
        corr = meas_value - st_r.ofs[ofs_idx(st_r.scan_mult, st_r.scan_nf)];
        sent = st_r.scan_mult ? (32'h0 - corr) : corr;
        cmd = dasc_cmd_t'(bus.wdata[CMD_CODE_LSB +: 4]);
        arg = bus.wdata[CMD_ARG_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.meas.req = 1'b0;
        st_nxt.rdata = 32'h0;

        // Pin synchronisers: accept a change once stages two and three agree
        st_nxt.op_sync = {st_r.op_sync[1:0], overpressure_pin};
        st_nxt.opt_sync = {st_r.opt_sync[1:0], option_pin};
        if (st_r.op_sync[1] == st_r.op_sync[2]) begin
            st_nxt.op_filt = st_r.op_sync[2];
        end
        if (st_r.opt_sync[1] == st_r.opt_sync[2]) begin
            st_nxt.opt_filt = st_r.opt_sync[2];
        end

        // Filament shutdown by overpressure drops the multiplier
        if (st_nxt.op_filt && !st_r.op_filt) begin
            st_nxt.mult = 1'b0;
            st_nxt.bias = 12'h0;
        end

        // Byte stream out, one bubble between bytes
        if (st_r.tx.valid && tx_ready) begin
            st_nxt.tx.valid = 1'b0;
        end
        if (!st_r.tx.valid && st_r.resp_cnt != 3'h0) begin
            st_nxt.tx.valid = 1'b1;
            st_nxt.tx.data = st_r.resp[7:0];
            st_nxt.resp = {8'h00, st_r.resp[31:8]};
            st_nxt.resp_cnt = st_r.resp_cnt - 3'h1;
        end

        // Scan sequencer
        case (st_r.state)
            S_ZREQ: begin
                st_nxt.meas.req = 1'b1;
                st_nxt.meas.zero_in = 1'b1;
                st_nxt.state = S_ZWAIT;
            end
            S_ZWAIT: begin
                if (meas_done) begin
                    st_nxt.ofs[ofs_idx(st_r.scan_mult, st_r.scan_nf)] = meas_value;
                    st_nxt.meas.zero_in = 1'b0;
                    st_nxt.idx = 16'h0;
                    st_nxt.settle_cnt = settle_len(st_r.scan_nf);
                    st_nxt.state = S_SETTLE;
                end
            end
            S_SETTLE: begin
                if (st_r.settle_cnt <= 24'h1) begin
                    st_nxt.state = S_PREQ;
                end else begin
                    st_nxt.settle_cnt = st_r.settle_cnt - 24'h1;
                end
            end
            S_PREQ: begin
                st_nxt.meas.req = 1'b1;
                st_nxt.state = S_PWAIT;
            end
            S_PWAIT: begin
                if (meas_done) begin
                    st_nxt.resp = sent;
                    st_nxt.resp_cnt = 3'h4;
                    st_nxt.state = S_PSEND;
                end
            end
            S_PSEND: begin
                // Next point waits for the stream to drain: host pace sets the rate
                if (st_r.resp_cnt == 3'h0 && !st_r.tx.valid) begin
                    if (st_r.idx == st_r.points - 16'h1) begin
                        st_nxt.state = S_TREQ;
                    end else begin
                        st_nxt.idx = st_r.idx + 16'h1;
                        st_nxt.settle_cnt = settle_len(st_r.scan_nf);
                        st_nxt.state = S_SETTLE;
                    end
                end
            end
            S_TREQ: begin
                if (st_r.scan_mult) begin
                    st_nxt.resp = 32'h0;
                    st_nxt.resp_cnt = 3'h4;
                    st_nxt.state = S_TSEND;
                end else begin
                    st_nxt.meas.req = 1'b1;
                    st_nxt.meas.tp = 1'b1;
                    st_nxt.state = S_TWAIT;
                end
            end
            S_TWAIT: begin
                if (meas_done) begin
                    st_nxt.meas.tp = 1'b0;
                    st_nxt.resp = sent;
                    st_nxt.resp_cnt = 3'h4;
                    st_nxt.state = S_TSEND;
                end
            end
            S_TSEND: begin
                if (st_r.resp_cnt == 3'h0 && !st_r.tx.valid) begin
                    if (st_r.cont || st_r.scans_left > 16'h1) begin
                        if (!st_r.cont) begin
                            st_nxt.scans_left = st_r.scans_left - 16'h1;
                        end
                        st_nxt.state = S_ZREQ;
                    end else begin
                        st_nxt.state = S_IDLE;
                    end
                end
            end
            S_CZWAIT: begin
                if (meas_done) begin
                    st_nxt.ofs[ofs_idx(st_r.scan_mult, st_r.scan_nf)] = meas_value;
                    st_nxt.meas.zero_in = 1'b0;
                    st_nxt.state = S_IDLE;
                end
            end
            S_IDLE: begin
            end
            default: begin
                st_nxt.state = S_IDLE;
            end
        endcase

        // Live measurement settings follow the latched scan detector
        st_nxt.meas.mult = st_nxt.scan_mult;
        st_nxt.meas.nf = st_nxt.scan_nf;
        st_nxt.meas.avg_shift = NF_FAST - st_nxt.scan_nf;

        ////////////////////////////////////////////////////////////////////////
        // Register port
        if (bus.rd) begin
            case (bus.addr)
                REG_NF: st_nxt.rdata = {29'h0, st_r.nf};
                REG_FIRST: st_nxt.rdata = {24'h0, st_r.first_mass};
                REG_FINAL: st_nxt.rdata = {24'h0, st_r.final_mass};
                REG_STEPS: st_nxt.rdata = {24'h0, st_r.steps_per_amu};
                REG_STAT: st_nxt.rdata = {20'h0, st_r.state != S_IDLE, st_r.opt_filt,
                                          st_r.total_pressure_allowed, st_r.mult, st_r.status};
                REG_POINTS: begin
                    st_nxt.rdata = {16'h0, scan_points(st_r.first_mass, st_r.final_mass,
                                                       st_r.steps_per_amu)};
                end
                REG_BIAS: st_nxt.rdata = {20'h0, st_r.bias};
                default: st_nxt.rdata = 32'h0;
            endcase
        end

        if (bus.wr) begin
            case (bus.addr)
                REG_NF: st_nxt.nf = bus.wdata[2:0];
                REG_FIRST: st_nxt.first_mass = bus.wdata[7:0];
                REG_FINAL: st_nxt.final_mass = bus.wdata[7:0];
                REG_STEPS: st_nxt.steps_per_amu = bus.wdata[7:0];
                default: begin
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // Command execution
        if (bus.wr && bus.addr == REG_CMD && cmd != CMD_NONE) begin
            // Halt any scan and drop queued bytes before the new command
            st_nxt.state = S_IDLE;
            st_nxt.resp_cnt = 3'h0;
            st_nxt.tx.valid = 1'b0;
            st_nxt.meas.req = 1'b0;
            st_nxt.meas.zero_in = 1'b0;
            st_nxt.meas.tp = 1'b0;
            case (cmd)
                CMD_SWEEP: begin
                    st_nxt.scan_mult = st_r.mult;
                    st_nxt.scan_nf = st_r.nf;
                    st_nxt.cont = (arg == 16'h0);
                    st_nxt.scans_left = arg;
                    st_nxt.points = scan_points(st_r.first_mass, st_r.final_mass,
                                                st_r.steps_per_amu);
                    if (st_r.first_mass > st_r.final_mass || st_r.steps_per_amu == 8'h0) begin
                        st_nxt.status[STAT_ERR_BIT] = 1'b1;
                    end else begin
                        st_nxt.state = S_ZREQ;
                    end
                end
                CMD_BIAS: begin
                    if (!st_r.opt_filt) begin
                        st_nxt.status[STAT_ERR_BIT] = 1'b1;
                        st_nxt.status[STAT_BIAS_BIT] = 1'b1;
                    end else begin
                        st_nxt.status[STAT_BIAS_BIT] = 1'b0;
                        st_nxt.bias = arg[11:0];
                        st_nxt.mult = (arg[11:0] != 12'h0);
                        if (arg[11:0] != 12'h0) begin
                            st_nxt.total_pressure_allowed = 1'b0;
                        end else begin
                            st_nxt.total_pressure_allowed = 1'b1;
                        end
                    end
                    st_nxt.resp = {24'h0, st_nxt.status};
                    st_nxt.resp_cnt = 3'h1;
                end
                CMD_OPT_Q: begin
                    st_nxt.resp = {8'h00, CHR_CR, CHR_LF,
                                   st_r.opt_filt ? CHR_ONE : CHR_ZERO};
                    st_nxt.resp_cnt = 3'h3;
                end
                CMD_ZERO: begin
                    st_nxt.scan_mult = st_r.mult;
                    st_nxt.scan_nf = st_r.nf;
                    st_nxt.meas.req = 1'b1;
                    st_nxt.meas.zero_in = 1'b1;
                    st_nxt.state = S_CZWAIT;
                end
                CMD_RECAL: begin
                    st_nxt.ofs = '0;
                    st_nxt.resp = {24'h0, st_r.status};
                    st_nxt.resp_cnt = 3'h1;
                end
                CMD_BIAS_Q: begin
                    st_nxt.resp = {20'h0, st_r.mult ? st_r.bias : 12'h0};
                    st_nxt.resp_cnt = 3'h4;
                end
                CMD_POINTS_Q: begin
                    st_nxt.resp = {16'h0, scan_points(st_r.first_mass, st_r.final_mass,
                                                      st_r.steps_per_amu)};
                    st_nxt.resp_cnt = 3'h4;
                end
                default: begin
                end
            endcase
            st_nxt.meas.mult = st_nxt.scan_mult;
            st_nxt.meas.nf = st_nxt.scan_nf;
            st_nxt.meas.avg_shift = NF_FAST - st_nxt.scan_nf;
        end
        // Busy flag registered so the output needs no decode
        st_nxt.busy = (st_nxt.state != S_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; offsets lost at power-off through reset

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.nf <= NF_RST;
            st_r.scan_nf <= NF_RST;
            st_r.meas.nf <= NF_RST;
            st_r.meas.avg_shift <= NF_FAST - NF_RST;
            st_r.first_mass <= FIRST_RST;
            st_r.final_mass <= FINAL_RST;
            st_r.steps_per_amu <= STEPS_RST;
            st_r.status <= STATUS_RST;
            st_r.mult <= 1'b0;
            st_r.total_pressure_allowed <= 1'b1;
            st_r.state <= S_IDLE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    always_comb begin
        rdata = st_r.rdata;
        meas = st_r.meas;
        tx = st_r.tx;
        step_idx = st_r.idx;
        multiplier_indicator = st_r.mult;
        scan_busy = st_r.busy;
    end

endmodule : dasc_ctrl

`default_nettype wire

/* rtl/dasc_pkg.sv */
// Shared constants and types for the detector and analog scan control
package dasc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_NF = 8'h04;
    localparam logic [7:0] REG_FIRST = 8'h08;
    localparam logic [7:0] REG_FINAL = 8'h0c;
    localparam logic [7:0] REG_STEPS = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] REG_POINTS = 8'h18;
    localparam logic [7:0] REG_BIAS = 8'h1c;

    // Command register fields
    localparam int CMD_CODE_LSB = 28;
    localparam int CMD_ARG_W = 16;

    // Values after reset
    localparam logic [2:0] NF_RST = 3'h2;
    localparam logic [7:0] FIRST_RST = 8'h01;
    localparam logic [7:0] FINAL_RST = 8'h41;
    localparam logic [7:0] STEPS_RST = 8'h0a;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // Fastest noise-floor setting, least averaging
    localparam logic [2:0] NF_FAST = 3'h7;

    // Status byte bits
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_BIAS_BIT = 3;

    // Timing
    localparam int CLK_PERIOD_NS = 5;

    // Reply characters
    localparam logic [7:0] CHR_ZERO = 8'h30;
    localparam logic [7:0] CHR_ONE = 8'h31;
    localparam logic [7:0] CHR_LF = 8'h0a;
    localparam logic [7:0] CHR_CR = 8'h0d;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_SWEEP = 4'h1,
        CMD_BIAS = 4'h2,
        CMD_OPT_Q = 4'h3,
        CMD_ZERO = 4'h4,
        CMD_RECAL = 4'h5,
        CMD_BIAS_Q = 4'h6,
        CMD_POINTS_Q = 4'h7
    } dasc_cmd_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ZREQ = 4'h1,
        S_ZWAIT = 4'h2,
        S_SETTLE = 4'h3,
        S_PREQ = 4'h4,
        S_PWAIT = 4'h5,
        S_PSEND = 4'h6,
        S_TREQ = 4'h7,
        S_TWAIT = 4'h8,
        S_TSEND = 4'h9,
        S_CZWAIT = 4'ha
    } dasc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dasc_bus_t;

    typedef struct packed {
        logic req;
        logic zero_in;
        logic tp;
        logic mult;
        logic [2:0] nf;
        logic [2:0] avg_shift;
    } dasc_meas_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } dasc_tx_t;

endpackage : dasc_pkg

/* verification/dasc_ctrl_assertions.sv */
// Port-level checker for the detector and scan control
`timescale 1ns/10ps
`default_nettype none
module dasc_ctrl_assertions #(
    parameter int STEP_SETTLE_NS = 1000
) (
    // Clock and control
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // Register port
    input wire dasc_pkg::dasc_bus_t bus,
    input wire logic [31:0] rdata,
    // Pins
    input wire logic overpressure_pin,
    input wire logic option_pin,
    // Electrometer and host
    input wire dasc_pkg::dasc_meas_t meas,
    input wire logic meas_done,
    input wire logic signed [31:0] meas_value,
    input wire logic [15:0] step_idx,
    input wire dasc_pkg::dasc_tx_t tx,
    input wire logic tx_ready,
    input wire logic multiplier_indicator,
    input wire logic scan_busy
);
    import dasc_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic cmd_wr;
    logic bias_nz;
    logic bias_z;
    assign cmd_wr = ce && bus.wr && bus.addr == REG_CMD && bus.wdata[31:28] inside {[4'h1:4'h7]};
    assign bias_nz = cmd_wr && bus.wdata[31:28] == CMD_BIAS && bus.wdata[11:0] != 12'h0;
    assign bias_z = cmd_wr && bus.wdata[31:28] == CMD_BIAS && bus.wdata[11:0] == 12'h0;
    // Strap must have crossed the synchroniser first
    sequence s_opt_on; option_pin [*5]; endsequence
    sequence s_opt_off; !option_pin [*5]; endsequence
    property p_bias_on; s_opt_on ##0 (bias_nz && !overpressure_pin) |=> multiplier_indicator; endproperty
    property p_bias_off; s_opt_on ##0 bias_z |=> !multiplier_indicator; endproperty
    property p_no_opt;
        s_opt_off ##0 (bias_nz && !multiplier_indicator) |=> !multiplier_indicator;
    endproperty
    property p_avg; meas.avg_shift == 3'h7 - meas.nf; endproperty
    property p_fast; meas.nf == NF_FAST |-> meas.avg_shift == 3'h0; endproperty
    property p_rezero;
        cmd_wr && bus.wdata[31:28] == CMD_SWEEP |-> ##2 ((meas.req && meas.zero_in) || !scan_busy);
    endproperty
    property p_zero_held;
        ce && meas.zero_in && !meas_done && !cmd_wr && scan_busy |=> meas.zero_in;
    endproperty
    property p_tp; meas.req && meas.tp |-> !meas.mult; endproperty
    property p_abort; cmd_wr |=> !tx.valid; endproperty
    property p_hold; ce && tx.valid && !tx_ready && !cmd_wr |=> tx.valid && $stable(tx.data); endproperty
    property p_pwr; $rose(nrst) |-> !multiplier_indicator && !meas.mult; endproperty
    a_bias_on: assert property (p_bias_on) else $error("bias did not enable multiplier");
    a_bias_off: assert property (p_bias_off) else $error("bias zero left multiplier on");
    a_no_opt: assert property (p_no_opt) else $error("bias ran without option");
    a_avg: assert property (p_avg) else $error("averaging not tied to noise floor");
    a_fast: assert property (p_fast) else $error("fastest floor not minimum averaging");
    a_rezero: assert property (p_rezero) else $error("scan did not start with zeroing");
    a_zero_held: assert property (p_zero_held) else $error("zero input dropped early");
    a_tp: assert property (p_tp) else $error("pressure measured on multiplier");
    a_abort: assert property (p_abort) else $error("transmit not flushed by command");
    a_hold: assert property (p_hold) else $error("byte changed before acceptance");
    a_pwr: assert property (p_pwr) else $error("multiplier active after reset");
endmodule : dasc_ctrl_assertions
bind dasc_ctrl dasc_ctrl_assertions #(.STEP_SETTLE_NS(STEP_SETTLE_NS)) chk_i (.core_clk(core_clk),
    .nrst(nrst), .ce(ce), .bus(bus), .rdata(rdata), .overpressure_pin(overpressure_pin),
    .option_pin(option_pin), .meas(meas), .meas_done(meas_done), .meas_value(meas_value),
    .step_idx(step_idx), .tx(tx), .tx_ready(tx_ready),
    .multiplier_indicator(multiplier_indicator), .scan_busy(scan_busy));
`default_nettype wire

/* verification/dasc_host_model.sv */
// Electrometer and host byte sink seen from the control block
`timescale 1ns/10ps
`default_nettype none
module dasc_host_model (
    // Clock and mode
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic slow,
    // Electrometer
    input wire dasc_pkg::dasc_meas_t meas,
    output logic meas_done,
    output logic signed [31:0] meas_value,
    // Host
    input wire dasc_pkg::dasc_tx_t tx,
    output logic tx_ready
);
    import dasc_pkg::*;
    localparam logic signed [31:0] ZOFF = 32'sh64;
    localparam logic signed [31:0] MVAL = 32'sh44c;
    logic busy;
    logic zin;
    logic [3:0] cnt;
    logic [1:0] rc;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            zin <= 1'b0;
            cnt <= 4'h0;
            rc <= 2'h0;
            meas_done <= 1'b0;
            meas_value <= 32'sh0;
            tx_ready <= 1'b0;
        end else begin
            meas_done <= 1'b0;
            // Value line toggles outside done so stale data never matches
            meas_value <= ~meas_value;
            if (meas.req) begin
                busy <= 1'b1;
                zin <= meas.zero_in;
                cnt <= slow ? 4'h9 : 4'h1;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                meas_done <= 1'b1;
                meas_value <= zin ? ZOFF : MVAL;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
            rc <= rc + 2'h1;
            tx_ready <= !slow || rc == 2'h0;
        end
    end
endmodule : dasc_host_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the detector and scan control
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
    import dasc_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic slow = 1'b0;
    logic op_pin = 1'b0;
    logic opt_pin = 1'b1;
    dasc_bus_t bus = '0;
    logic [31:0] rdata;
    logic [31:0] rv;
    dasc_meas_t meas;
    logic meas_done;
    logic signed [31:0] meas_value;
    dasc_tx_t tx;
    logic tx_ready;
    logic mult_ind;
    logic scan_busy;
    logic [7:0] rx_q[$];
    int n_fail = 0;
    int check_count = 0;
    always #2.5 core_clk = ~core_clk;
    dasc_ctrl #(.STEP_SETTLE_NS(20)) dasc_ctrl_i (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .bus(bus), .rdata(rdata), .overpressure_pin(op_pin), .option_pin(opt_pin), .meas(meas),
        .meas_done(meas_done), .meas_value(meas_value), .step_idx(), .tx(tx),
        .tx_ready(tx_ready), .multiplier_indicator(mult_ind), .scan_busy(scan_busy));
    dasc_host_model dasc_host_model_i (.core_clk(core_clk), .nrst(nrst), .slow(slow),
        .meas(meas), .meas_done(meas_done), .meas_value(meas_value), .tx(tx),
        .tx_ready(tx_ready));
    always @(posedge core_clk) if (tx.valid && tx_ready) rx_q.push_back(tx.data);
    ////////////////////////////////////////////////////////////
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk) bus.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge core_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk) bus.rd <= 1'b0;
        #1 rv = rdata;
    endtask : rd
    // Bytes left over from before the command are of no interest
    task cmd(input dasc_cmd_t c, input logic [15:0] arg);
        wr(REG_CMD, {c, 12'h0, arg});
        @(posedge core_clk) rx_q.delete();
    endtask : cmd
    task wait_n(input int n);
        for (int i = 0; i < 3000 && rx_q.size() < n; i++) @(posedge core_clk);
        if (rx_q.size() < n) begin
            n_fail++;
            $display("mismatch t=%0t byte wait", $time);
            while (rx_q.size() < n) rx_q.push_back(8'h0);
        end
    endtask : wait_n
    task exp_byte(input logic [7:0] b);
        logic [7:0] g;
        wait_n(1);
        g = rx_q.pop_front();
        `CHK(g, b)
    endtask : exp_byte
    task exp_word(input logic [31:0] w);
        logic [31:0] g;
        wait_n(4);
        g = {rx_q[3], rx_q[2], rx_q[1], rx_q[0]};
        repeat (4) void'(rx_q.pop_front());
        `CHK(g, w)
    endtask : exp_word
    ////////////////////////////////////////////////////////////
    task t_regs;
        rd(REG_STAT); `CHK(rv, 32'h600)
        rd(REG_POINTS); `CHK(rv, 32'h281)
        rd(8'h20); `CHK(rv, 32'h0)
    endtask : t_regs
    task t_option;
        cmd(CMD_OPT_Q, 16'h0);
        exp_byte(CHR_ONE);
        exp_byte(CHR_LF);
        exp_byte(CHR_CR);
    endtask : t_option
    task t_bias;
        cmd(CMD_BIAS, 16'h578);
        `CHK(mult_ind, 1'b1)
        exp_byte(8'h00);
        rd(REG_STAT); `CHK(rv[9], 1'b0)
        cmd(CMD_BIAS_Q, 16'h0);
        exp_word(32'h578);
        op_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        `CHK(mult_ind, 1'b0)
        op_pin <= 1'b0;
        cmd(CMD_BIAS, 16'h0);
        exp_byte(8'h00);
        `CHK(mult_ind, 1'b0)
    endtask : t_bias
    task t_scan_fc;
        wr(REG_NF, 32'h7);
        wr(REG_FIRST, 32'h5);
        wr(REG_FINAL, 32'h6);
        wr(REG_STEPS, 32'h2);
        rd(REG_POINTS); `CHK(rv, 32'h3)
        cmd(CMD_SWEEP, 16'h2);
        `CHK(meas.nf, 3'h7)
        // Offset 100 from zeroing, raw 1100 per point
        repeat (2) begin
            repeat (3) exp_word(32'h3e8);
            exp_word(32'h3e8);
        end
        for (int i = 0; i < 200 && scan_busy; i++) @(posedge core_clk);
        `CHK(scan_busy, 1'b0)
        `CHK(rx_q.size(), 0)
    endtask : t_scan_fc
    task t_scan_mult;
        slow <= 1'b1;
        cmd(CMD_BIAS, 16'h578);
        exp_byte(8'h00);
        cmd(CMD_SWEEP, 16'h1);
        // Overpressure mid-scan drops the multiplier but not the scan's detector
        op_pin <= 1'b1;
        repeat (3) exp_word(32'hfffffc18);
        `CHK(mult_ind, 1'b0)
        `CHK(meas.mult, 1'b1)
        exp_word(32'h0);
        op_pin <= 1'b0;
        slow <= 1'b0;
        cmd(CMD_BIAS, 16'h0);
        exp_byte(8'h00);
    endtask : t_scan_mult
    task t_abort;
        cmd(CMD_SWEEP, 16'h0);
        wait_n(6);
        cmd(CMD_POINTS_Q, 16'h0);
        exp_word(32'h3);
        repeat (50) @(posedge core_clk);
        `CHK(rx_q.size(), 0)
        `CHK(scan_busy, 1'b0)
    endtask : t_abort
    task t_noopt;
        opt_pin <= 1'b0;
        repeat (5) @(posedge core_clk);
        cmd(CMD_BIAS, 16'h578);
        exp_byte(8'h09);
        `CHK(mult_ind, 1'b0)
    endtask : t_noopt
    task t_zero;
        wr(REG_FIRST, 32'h7);
        cmd(CMD_SWEEP, 16'h1);
        `CHK(scan_busy, 1'b0)
        cmd(CMD_ZERO, 16'h0);
        `CHK(meas.zero_in, 1'b1)
        for (int i = 0; i < 20 && scan_busy; i++) @(posedge core_clk);
        `CHK(scan_busy, 1'b0)
        cmd(CMD_RECAL, 16'h0);
        exp_byte(8'h09);
    endtask : t_zero
    ////////////////////////////////////////////////////////////
    task final_report;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge core_clk);
        t_regs();
        t_option();
        t_bias();
        t_scan_fc();
        t_scan_mult();
        t_abort();
        t_noopt();
        t_zero();
        final_report();
    end
endmodule : tb
`default_nettype wire
